// ---- include/sout_pkg.sv ----
/*
 * constants for the serial audio output port: register map, field
 * positions, codes and clock ratios.
 * assumes nothing; imported by nobody, used as sout_pkg::name.
 */
package sout_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_FLOW = 7'h03;
  localparam logic [6:0] ADDR_CLKSRC = 7'h04;
  localparam logic [6:0] ADDR_FMT = 7'h06;
  localparam logic [6:0] ADDR_STAT = 7'h7f;
  localparam logic [7:0] FLOW_RST = 8'h00;
  localparam logic [7:0] CLKSRC_RST = 8'h00;
  localparam logic [7:0] FMT_RST = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FMT_MASTER = 7;
  localparam int FMT_RATE = 6;
  localparam int FMT_RES_HI = 5;
  localparam int FMT_RES_LO = 4;
  localparam int FMT_JUST = 3;
  localparam int FMT_DEL = 2;
  localparam int FMT_LRPOL = 0;
  localparam int FLOW_SPD_HI = 2;
  localparam int FLOW_SPD_LO = 1;
  localparam int CLK_RATIO_HI = 5;
  localparam int CLK_RATIO_LO = 4;
  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RES_24 = 2'h0;
  localparam logic [1:0] RES_20 = 2'h1;
  localparam logic [1:0] RES_16 = 2'h2;
  localparam logic [1:0] RES_RAW = 2'h3;
  localparam logic [1:0] SRC_RATE = 2'h0;
  localparam logic [1:0] SRC_SERIN = 2'h1;
  localparam logic [1:0] SRC_AES = 2'h2;
  localparam logic [1:0] RATIO_384 = 2'h1;
  localparam logic [1:0] RATIO_512 = 2'h2;
  // ---------------------------------------------------------------
  // widths and clock multiples
  // ---------------------------------------------------------------
  localparam int PCM_W = 24;
  localparam int RAW_W = 27;
  localparam int SLOT_W = 28;
  localparam logic [7:0] BITS_24 = 8'h18;
  localparam logic [7:0] BITS_20 = 8'h14;
  localparam logic [7:0] BITS_16 = 8'h10;
  localparam logic [7:0] BITS_RAW = 8'h1c;
  localparam logic [9:0] MCLK_256 = 10'h100;
  localparam logic [9:0] MCLK_384 = 10'h180;
  localparam logic [9:0] MCLK_512 = 10'h200;
  localparam logic [7:0] BCLK_64 = 8'h40;
  localparam logic [7:0] BCLK_128 = 8'h80;
endpackage

// ---- hdl/two_entry_buf.sv ----
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
module two_entry_buf #(
  parameter int W = 56
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic push_w;
  logic pop_w;

  // handshake decode
  assign push_w = in_valid_i & in_ready_o;
  assign pop_w = out_ready_i & out_valid_o;
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign count_nxt = count_r + {1'b0, push_w} - {1'b0, pop_w};

  // pointers, fill level, registered ready
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      in_ready_o <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push_w;
      rd_ptr_r <= rd_ptr_r ^ pop_w;
      count_r <= count_nxt;
      in_ready_o <= (count_nxt != 2'h2);
    end
  end

  // storage
  always_ff @(posedge clk_i) begin
    if (push_w) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
endmodule // two_entry_buf

// ---- hdl/serial_out_port.sv ----
/*
 * serial audio output port: format registers, source select, master
 * clock generation or slave clock tracking, and the serial shifter.
 * assumes clk_i is the output master clock; pins are synchronised here.
 */
module serial_out_port (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic rate_valid_i,
  input wire logic [23:0] rate_left_i,
  input wire logic [23:0] rate_right_i,
  input wire logic serin_valid_i,
  input wire logic [23:0] serin_left_i,
  input wire logic [23:0] serin_right_i,
  input wire logic aes_valid_i,
  input wire logic [23:0] aes_left_i,
  input wire logic [23:0] aes_right_i,
  input wire logic [26:0] aes_raw_left_i,
  input wire logic [26:0] aes_raw_right_i,
  input wire logic aes_block_start_i,
  output logic src_ready_o,
  input wire logic bitclk_i,
  output logic bitclk_o,
  output logic bitclk_oe_o,
  input wire logic wordclk_i,
  output logic wordclk_o,
  output logic wordclk_oe_o,
  output logic serial_data_output_o
);
  localparam int SW = sout_pkg::SLOT_W;
  localparam logic [SW-1:0] SLOT_ZERO = '0;
  localparam int PCM_PAD = sout_pkg::SLOT_W - sout_pkg::PCM_W;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // clk cycles per bit: master ratio over bit clock multiple
  function automatic logic [7:0] bit_div(input logic [1:0] ratio, input logic rate);
    logic [9:0] m;
    logic [9:0] q;
    m = (ratio == sout_pkg::RATIO_384) ? sout_pkg::MCLK_384 :
        (ratio == sout_pkg::RATIO_512) ? sout_pkg::MCLK_512 : sout_pkg::MCLK_256;
    q = m / {2'h0, (rate ? sout_pkg::BCLK_128 : sout_pkg::BCLK_64)};
    return q[7:0];
  endfunction

  function automatic logic [SW-1:0] pcm_slot(input logic [23:0] s);
    return {s, {PCM_PAD{1'b0}}};
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] flow_r;
  logic [7:0] clksrc_r;
  logic [7:0] fmt_r;
  logic master_w;
  logic rate_w;
  logic [1:0] res_w;
  logic [1:0] spd_w;
  logic [1:0] ratio_w;
  logic raw_w;
  logic [7:0] div_w;
  logic [7:0] half_w;
  logic [7:0] width_w;
  logic [7:0] start_w;
  logic [7:0] stat_w;
  logic buf_valid_w;
  logic chan_left_r;

  // field decode
  assign master_w = fmt_r[sout_pkg::FMT_MASTER];
  assign rate_w = fmt_r[sout_pkg::FMT_RATE];
  assign res_w = fmt_r[sout_pkg::FMT_RES_HI:sout_pkg::FMT_RES_LO];
  assign spd_w = flow_r[sout_pkg::FLOW_SPD_HI:sout_pkg::FLOW_SPD_LO];
  assign ratio_w = clksrc_r[sout_pkg::CLK_RATIO_HI:sout_pkg::CLK_RATIO_LO];
  assign raw_w = (res_w == sout_pkg::RES_RAW);
  assign div_w = bit_div(ratio_w, rate_w);
  assign half_w = (rate_w ? sout_pkg::BCLK_128 : sout_pkg::BCLK_64) >> 1;
  assign width_w = (res_w == sout_pkg::RES_20) ? sout_pkg::BITS_20 :
                   (res_w == sout_pkg::RES_16) ? sout_pkg::BITS_16 :
                   raw_w ? sout_pkg::BITS_RAW : sout_pkg::BITS_24;
  assign start_w = (master_w & fmt_r[sout_pkg::FMT_JUST]) ? (half_w - width_w)
                 : {7'h00, fmt_r[sout_pkg::FMT_DEL]};
  assign stat_w = {5'h00, buf_valid_w, chan_left_r, master_w};

  // register writes and registered read data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flow_r <= sout_pkg::FLOW_RST;
      clksrc_r <= sout_pkg::CLKSRC_RST;
      fmt_r <= sout_pkg::FMT_RST;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == sout_pkg::ADDR_FLOW) flow_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == sout_pkg::ADDR_CLKSRC) clksrc_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == sout_pkg::ADDR_FMT) fmt_r <= reg_wdata_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          sout_pkg::ADDR_FLOW: reg_rdata_o <= flow_r;
          sout_pkg::ADDR_CLKSRC: reg_rdata_o <= clksrc_r;
          sout_pkg::ADDR_FMT: reg_rdata_o <= fmt_r;
          sout_pkg::ADDR_STAT: reg_rdata_o <= stat_w;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // source select and buffer
  // ---------------------------------------------------------------
  logic in_valid_w;
  logic [2*SW-1:0] in_data_w;
  logic [2*SW-1:0] buf_data_w;
  logic pop_w;
  logic push_w;

  // source mux, raw resolution always takes aes; otherwise reserved code feeds nothing
  assign in_valid_w = raw_w ? aes_valid_i :
                      (spd_w == sout_pkg::SRC_RATE) ? rate_valid_i :
                      (spd_w == sout_pkg::SRC_SERIN) ? serin_valid_i :
                      (spd_w == sout_pkg::SRC_AES) ? aes_valid_i : 1'b0;
  // raw word with block start in parity slot
  assign in_data_w = raw_w ? {aes_raw_left_i, aes_block_start_i, aes_raw_right_i, aes_block_start_i} :
                     (spd_w == sout_pkg::SRC_SERIN) ? {pcm_slot(serin_left_i), pcm_slot(serin_right_i)} :
                     (spd_w == sout_pkg::SRC_AES) ? {pcm_slot(aes_left_i), pcm_slot(aes_right_i)} :
                     {pcm_slot(rate_left_i), pcm_slot(rate_right_i)};
  assign push_w = in_valid_w & src_ready_o;

  two_entry_buf #(.W(2*SW)) u_buf (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(in_valid_w),
    .in_ready_o(src_ready_o),
    .in_data_i(in_data_w),
    .out_valid_o(buf_valid_w),
    .out_ready_i(pop_w),
    .out_data_o(buf_data_w)
  );

  // ---------------------------------------------------------------
  // clock tracking and generation
  // ---------------------------------------------------------------
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_d_r;
  logic lr_s1_r;
  logic lr_s2_r;
  logic lr_last_r;
  logic [7:0] div_cnt_r;
  logic [7:0] div_cnt_nxt;
  logic [7:0] pos_r;
  logic [7:0] pos_nxt;
  logic tick_w;
  logic launch_w;
  logic newch_w;
  logic next_left_w;

  // two-flop pin synchronisers
  always_ff @(posedge clk_i) begin
    sck_s1_r <= bitclk_i;
    sck_s2_r <= sck_s1_r;
    sck_d_r <= sck_s2_r;
    lr_s1_r <= wordclk_i;
    lr_s2_r <= lr_s1_r;
  end

  // launch source by mode
  // at or past the end, so a smaller ratio written mid-count never wraps the counter
  assign tick_w = (div_cnt_r >= div_w - 8'h01);
  assign div_cnt_nxt = (!master_w || tick_w) ? 8'h00 : div_cnt_r + 8'h01;
  assign launch_w = master_w ? tick_w : (sck_d_r & ~sck_s2_r);
  // at or past the slot end: a shorter slot written mid-slot must not stall framing
  assign newch_w = master_w ? (pos_r >= half_w - 8'h01) : (lr_s2_r != lr_last_r);
  assign next_left_w = master_w ? ~chan_left_r : (lr_s2_r ^ fmt_r[sout_pkg::FMT_LRPOL]);
  assign pos_nxt = newch_w ? 8'h00 : (pos_r == 8'hff) ? pos_r : pos_r + 8'h01;

  // divider, slot counter and clock pins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_cnt_r <= 8'h00;
      pos_r <= 8'h00;
      chan_left_r <= 1'b0;
      lr_last_r <= 1'b0;
      bitclk_o <= 1'b0;
      wordclk_o <= 1'b0;
      bitclk_oe_o <= 1'b0;
      wordclk_oe_o <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      bitclk_o <= master_w & (div_cnt_nxt >= (div_w >> 1));
      bitclk_oe_o <= master_w;
      wordclk_oe_o <= master_w;
      if (launch_w) begin
        pos_r <= pos_nxt;
        lr_last_r <= lr_s2_r;
        if (newch_w) chan_left_r <= next_left_w;
        if (newch_w && master_w) wordclk_o <= next_left_w ^ fmt_r[sout_pkg::FMT_LRPOL];
      end
    end
  end

  // ---------------------------------------------------------------
  // shifter
  // ---------------------------------------------------------------
  logic [SW-1:0] shreg_r;
  logic [SW-1:0] hold_r;
  logic [SW-1:0] cur_w;
  logic in_win_w;

  assign pop_w = launch_w & newch_w & next_left_w;
  assign cur_w = !(launch_w && newch_w) ? shreg_r :
                 !next_left_w ? hold_r :
                 buf_valid_w ? buf_data_w[2*SW-1:SW] : SLOT_ZERO;
  // bits outside the word read zero
  assign in_win_w = (pos_nxt >= start_w) && (pos_nxt < start_w + width_w);

  // serial data, one bit per launch
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      shreg_r <= SLOT_ZERO;
      hold_r <= SLOT_ZERO;
      serial_data_output_o <= 1'b0;
    end else if (launch_w) begin
      serial_data_output_o <= in_win_w & cur_w[SW-1];
      shreg_r <= in_win_w ? {cur_w[SW-2:0], 1'b0} : cur_w;
      if (pop_w) hold_r <= buf_valid_w ? buf_data_w[SW-1:0] : SLOT_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic bitclk_d_r;
  logic wordclk_d_r;
  logic [7:0] gap_r;
  logic [7:0] nb_r;
  logic arm0_r;
  logic arm_r;
  logic warm_r;
  logic rise_w;
  logic wchg_w;

  assign rise_w = bitclk_o & ~bitclk_d_r;
  assign wchg_w = wordclk_o ^ wordclk_d_r;

  // pin delays for edge detect, never cleared by writes to avoid false edges
  always_ff @(posedge clk_i) begin
    bitclk_d_r <= bitclk_o;
    wordclk_d_r <= wordclk_o;
  end

  // edge spacing helpers, cleared on any write; second rise arms the period check
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || reg_wr_i) begin
      gap_r <= 8'h00;
      nb_r <= 8'h00;
      arm0_r <= 1'b0;
      arm_r <= 1'b0;
      warm_r <= 1'b0;
    end else begin
      gap_r <= rise_w ? 8'h01 : gap_r + {7'h00, gap_r != 8'hff};
      nb_r <= wchg_w ? 8'h00 : nb_r + {7'h00, rise_w};
      arm0_r <= arm0_r | rise_w;
      arm_r <= arm_r | (rise_w & arm0_r);
      warm_r <= warm_r | wchg_w;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_slave_release;
    !master_w ##1 !master_w |-> !bitclk_oe_o && !wordclk_oe_o && !bitclk_o;
  endproperty
  a_slave_release: assert property (p_slave_release) else $error("slave mode drives a clock pin");

  property p_master_drive;
    master_w ##1 master_w |-> bitclk_oe_o && wordclk_oe_o;
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("master mode leaves clock pins undriven");

  property p_bits_per_slot;
    master_w && warm_r && wchg_w |-> nb_r == half_w;
  endproperty
  a_bits_per_slot: assert property (p_bits_per_slot) else $error("wrong bit count per word clock half");

  property p_bitclk_period;
    master_w && arm_r && rise_w |-> gap_r == div_w;
  endproperty
  a_bitclk_period: assert property (p_bitclk_period) else $error("bit clock period off ratio");

  property p_word_width;
    launch_w && !((pos_nxt >= start_w) && (pos_nxt < start_w + width_w)) |=> !serial_data_output_o;
  endproperty
  a_word_width: assert property (p_word_width) else $error("data driven outside the word");

  property p_reserved_src;
    !raw_w && spd_w == 2'h3 |-> !push_w;
  endproperty
  a_reserved_src: assert property (p_reserved_src) else $error("reserved source accepted a word");

  property p_raw_flag;
    raw_w && push_w |-> in_data_w[0] == aes_block_start_i && in_data_w[SW] == aes_block_start_i;
  endproperty
  a_raw_flag: assert property (p_raw_flag) else $error("raw word lacks block start flag");

  property p_slave_left;
    !master_w |-> start_w == {7'h00, fmt_r[sout_pkg::FMT_DEL]};
  endproperty
  a_slave_left: assert property (p_slave_left) else $error("slave mode not left justified");

  c_master_frame: cover property (master_w && warm_r && wchg_w);
  c_raw_push: cover property (raw_w && push_w);
  c_slave_pop: cover property (!master_w && pop_w && buf_valid_w);
endmodule // serial_out_port

// ---- verif/audio_sink_model.sv ----
/*
 * behavioural audio sink on the far side of the serial output port.
 * assumes clk_i is the bench master clock; slots are framed by word clock edges.
 */
module audio_sink_model (
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic bit_line_i,
  input wire logic word_line_i,
  input wire logic data_i,
  output logic bitclk_o,
  output logic wordclk_o,
  output logic slot_done_o,
  output logic slot_left_o,
  output logic [63:0] slot_bits_o,
  output logic [7:0] slot_len_o
);
  logic [3:0] div_r = 4'h0;
  logic [5:0] bit_cnt_r = 6'h00;
  logic tog_r = 1'b0;
  logic bit_prev_r = 1'b0;
  logic word_prev_r = 1'b0;
  logic [63:0] sh_r = 64'h0;
  logic [7:0] n_r = 8'h00;
  // ---------------------------------------------------------------
  // clock source
  // ---------------------------------------------------------------
  // sink supplies both clocks while the port is slave
  always_ff @(posedge clk_i) begin
    tog_r <= ~tog_r;
    div_r <= div_r + 4'h1;
    if (div_r == 4'hf) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end
  // released clocks show a changing pattern, not a held level
  assign bitclk_o = drive_i ? div_r[3] : tog_r;
  assign wordclk_o = drive_i ? ~bit_cnt_r[5] : tog_r;
  // ---------------------------------------------------------------
  // slot capture
  // ---------------------------------------------------------------
  // bits taken msb first on rising bit clock
  always_ff @(posedge clk_i) begin
    bit_prev_r <= bit_line_i;
    slot_done_o <= 1'b0;
    if (bit_line_i && !bit_prev_r) begin
      word_prev_r <= word_line_i;
      if (word_line_i != word_prev_r) begin
        slot_done_o <= 1'b1;
        slot_left_o <= word_prev_r;
        slot_bits_o <= sh_r;
        slot_len_o <= n_r;
        sh_r <= {63'h0, data_i};
        n_r <= 8'h01;
      end else begin
        sh_r <= {sh_r[62:0], data_i};
        n_r <= n_r + 8'h01;
      end
    end
  end
endmodule // audio_sink_model

// ---- verif/serial_out_port_tb_top.sv ----
/*
 * self-checking bench for the serial output port: register access, slave and
 * master clocking, word formats, sources and the two-entry buffer.
 * assumes the sink model drives the clocks whenever the port does not.
 */
module serial_out_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic rate_valid_i = 1'b1;
  logic serin_valid_i = 1'b1;
  logic aes_valid_i = 1'b1;
  logic aes_block_start_i = 1'b1;
  logic [23:0] rate_l = 24'hc3a5e1;
  logic [23:0] rate_r = 24'h5a1e3c;
  logic [23:0] serin_l = 24'h9b7d11;
  logic [23:0] serin_r = 24'h1234ab;
  logic [23:0] aes_l = 24'hd24c87;
  logic [23:0] aes_r = 24'h6e05f9;
  logic [26:0] raw_l = 27'h6d2b4c9;
  logic [26:0] raw_r = 27'h13a5f06;
  logic [7:0] reg_rdata_o;
  logic src_ready_o, bitclk_o, bitclk_oe_o, wordclk_o, wordclk_oe_o, serial_data_output_o;
  logic sink_bclk, sink_wclk, slot_done, slot_left, bit_line, word_line;
  logic [63:0] slot_bits, bits_v, mclk_v, bclk_v, exp_v;
  logic [7:0] slot_len, len_v;
  logic [31:0] per_v;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ---------------------------------------------------------------
  // clock, pins and instances
  // ---------------------------------------------------------------
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  assign bit_line = bitclk_oe_o ? bitclk_o : sink_bclk;
  assign word_line = wordclk_oe_o ? wordclk_o : sink_wclk;
  serial_out_port u_serial_out_port (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rate_valid_i(rate_valid_i), .rate_left_i(rate_l), .rate_right_i(rate_r),
    .serin_valid_i(serin_valid_i), .serin_left_i(serin_l), .serin_right_i(serin_r),
    .aes_valid_i(aes_valid_i), .aes_left_i(aes_l), .aes_right_i(aes_r), .aes_raw_left_i(raw_l),
    .aes_raw_right_i(raw_r), .aes_block_start_i(aes_block_start_i), .src_ready_o(src_ready_o),
    .bitclk_i(bit_line), .bitclk_o(bitclk_o), .bitclk_oe_o(bitclk_oe_o), .wordclk_i(word_line),
    .wordclk_o(wordclk_o), .wordclk_oe_o(wordclk_oe_o), .serial_data_output_o(serial_data_output_o));
  audio_sink_model u_audio_sink_model (.clk_i(clk_i), .drive_i(~bitclk_oe_o), .bit_line_i(bit_line),
    .word_line_i(word_line), .data_i(serial_data_output_o), .bitclk_o(sink_bclk), .wordclk_o(sink_wclk),
    .slot_done_o(slot_done), .slot_left_o(slot_left), .slot_bits_o(slot_bits), .slot_len_o(slot_len));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    cmp_count++;
    if (reg_rdata_o !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, reg_rdata_o, exp);
    end
  endtask
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // fourth matching slot: in-progress slot and both buffered words are gone
  task automatic get_slot(input logic left, output logic [63:0] b, output logic [7:0] n);
    int seen;
    seen = 0;
    for (int k = 0; k < 8000 && seen < 4; k++) begin
      @(posedge clk_i);
      #1;
      if (slot_done === 1'b1 && slot_left === left) begin
        seen++;
      end
    end
    if (seen < 4) begin
      n_fail++;
    end
    b = slot_bits;
    n = slot_len;
  endtask
  task automatic chk_slot(input logic left, input logic [31:0] exp);
    get_slot(left, bits_v, len_v);
    chk_word({24'h0, len_v, bits_v[31:0]}, {24'h0, 8'h20, exp});
  endtask
  task automatic bit_per(output logic [31:0] p);
    logic prev;
    int rises;
    prev = bitclk_o;
    rises = 0;
    p = 32'h0;
    for (int k = 0; k < 200 && rises < 2; k++) begin
      @(posedge clk_i);
      #1;
      if (rises == 1) begin
        p++;
      end
      if (bitclk_o === 1'b1 && prev !== 1'b1) begin
        rises++;
      end
      prev = bitclk_o;
    end
  endtask
  // ---------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk_reg(sout_pkg::ADDR_FMT, sout_pkg::FMT_RST);
    chk_reg(sout_pkg::ADDR_FLOW, sout_pkg::FLOW_RST);
    chk_reg(sout_pkg::ADDR_CLKSRC, sout_pkg::CLKSRC_RST);
    reg_wr(sout_pkg::ADDR_FMT, 8'h5d);
    chk_reg(sout_pkg::ADDR_FMT, 8'h5d);
    reg_wr(7'h10, 8'hff);
    chk_reg(7'h10, 8'h00);
    reg_wr(sout_pkg::ADDR_FMT, 8'h00);
    $display("test registers done");
    chk_slot(1'b1, {rate_l, 8'h00});
    chk_slot(1'b0, {rate_r, 8'h00});
    reg_wr(sout_pkg::ADDR_FMT, 8'h08);
    chk_slot(1'b1, {rate_l, 8'h00});
    chk_word({62'h0, bitclk_oe_o, wordclk_oe_o}, 64'h0);
    $display("test slave done");
    for (int r = 0; r < 3; r++) begin
      for (int s = 0; s < 2; s++) begin
        reg_wr(sout_pkg::ADDR_CLKSRC, {2'b00, 2'(r), 4'h0});
        reg_wr(sout_pkg::ADDR_FMT, {1'b1, 1'(s), 6'h00});
        mclk_v = (r == 0) ? {54'h0, sout_pkg::MCLK_256} : (r == 1) ? {54'h0, sout_pkg::MCLK_384} : {54'h0, sout_pkg::MCLK_512};
        bclk_v = (s == 0) ? {56'h0, sout_pkg::BCLK_64} : {56'h0, sout_pkg::BCLK_128};
        get_slot(1'b1, bits_v, len_v);
        chk_word({56'h0, len_v}, bclk_v >> 1);
        bit_per(per_v);
        chk_word({32'h0, per_v}, mclk_v / bclk_v);
      end
    end
    chk_word({62'h0, bitclk_oe_o, wordclk_oe_o}, 64'h3);
    $display("test master clocks done");
    reg_wr(sout_pkg::ADDR_CLKSRC, 8'h00);
    for (int c = 0; c < 5; c++) begin
      case (c)
        0: exp_v = {32'h0, rate_l, 8'h00};
        1: exp_v = {32'h0, rate_l[23:4], 12'h000};
        2: exp_v = {32'h0, rate_l[23:8], 16'h0000};
        3: exp_v = {40'h0, rate_l};
        default: exp_v = {33'h0, rate_l, 7'h00};
      endcase
      reg_wr(sout_pkg::ADDR_FMT, (c == 4) ? 8'h84 : (c == 3) ? 8'h88 : {2'b10, 2'(c), 4'h0});
      chk_slot(1'b1, exp_v[31:0]);
    end
    reg_wr(sout_pkg::ADDR_FMT, 8'h81);
    chk_slot(1'b0, {rate_l, 8'h00});
    $display("test formats done");
    reg_wr(sout_pkg::ADDR_FMT, 8'h80);
    reg_wr(sout_pkg::ADDR_FLOW, 8'h02);
    chk_slot(1'b1, {serin_l, 8'h00});
    reg_wr(sout_pkg::ADDR_FLOW, 8'h04);
    chk_slot(1'b1, {aes_l, 8'h00});
    reg_wr(sout_pkg::ADDR_FMT, 8'hb0);
    chk_slot(1'b1, {raw_l, 1'b1, 4'h0});
    @(negedge clk_i);
    aes_block_start_i = 1'b0;
    chk_slot(1'b0, {raw_r, 1'b0, 4'h0});
    reg_wr(sout_pkg::ADDR_FMT, 8'h80);
    reg_wr(sout_pkg::ADDR_FLOW, 8'h06);
    chk_slot(1'b1, 32'h0);
    chk_word({63'h0, src_ready_o}, 64'h1);
    $display("test sources done");
    reg_wr(sout_pkg::ADDR_FLOW, 8'h00);
    repeat (4) @(negedge clk_i);
    chk_word({63'h0, src_ready_o}, 64'h0);
    rate_valid_i = 1'b0;
    chk_slot(1'b1, 32'h0);
    chk_word({63'h0, src_ready_o}, 64'h1);
    $display("test buffer done");
    close_out();
  end
endmodule // serial_out_port_tb_top
